// file: rtl/cwg_pkg.sv
// Purpose: Shared constants of the complementary waveform mode block
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: Byte offsets, field positions and reset values
package cwg_pkg;

    localparam int DB_W = 6;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_POL = 8'h04;
    localparam logic [7:0] OFS_DBR = 8'h08;
    localparam logic [7:0] OFS_DBF = 8'h0C;
    localparam logic [7:0] OFS_STEER = 8'h10;
    localparam logic [7:0] OFS_SHDN = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_LD_BIT = 6;
    localparam int CTRL_EN_BIT = 7;
    localparam int STEER_STR_LSB = 0;
    localparam int STEER_SDAT_LSB = 8;
    localparam int SHDN_LVL_LSB = 0;
    localparam int SHDN_SW_BIT = 7;
    localparam int STAT_OUT_LSB = 0;
    localparam int STAT_SHDN_BIT = 4;
    localparam int STAT_DIR_BIT = 5;
    localparam int STAT_PP_BIT = 6;
    localparam int STAT_DBR_LSB = 8;
    localparam int STAT_DBF_LSB = 16;

    // ------------------------------------------------------------
    // Mode codes
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_ASTEER = 3'h0;
    localparam logic [2:0] MODE_SSTEER = 3'h1;
    localparam logic [2:0] MODE_FWD = 3'h2;
    localparam logic [2:0] MODE_REV = 3'h3;
    localparam logic [2:0] MODE_HALF = 3'h4;
    localparam logic [2:0] MODE_PUSH = 3'h5;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [2:0] RST_MODE = 3'h0;
    localparam logic [3:0] RST_POL = 4'hF;
    localparam logic [DB_W-1:0] RST_DB = 6'h00;
    localparam logic [3:0] RST_STR = 4'h0;
    localparam logic [3:0] RST_SDAT = 4'h0;
    localparam logic [3:0] RST_SHDN_LVL = 4'h0;

endpackage

// file: rtl/cwg_db_if.sv
// Purpose: Link between the mode logic and one dead-band timer
// Assumes: Same clock on both sides
// Notes: level_in low holds the timer cleared
`timescale 1ns/1ns
interface cwg_db_if;
    logic level_in;
    logic [5:0] count;
    logic out;
    modport user (output level_in, output count, input out);
    modport timer (input level_in, input count, output out);
endinterface

// file: rtl/cwg_deadband.sv
// Purpose: One dead-band timer delaying the turn-on of an output
// Assumes: level_in is already synchronous to clk_sys
// Notes: Output rises count+1 cycles after level_in rises
`timescale 1ns/1ns
module cwg_deadband
(
    input wire logic clk_sys,
    input wire logic rst,
    cwg_db_if.timer db
);

    logic [5:0] cnt_q;
    logic out_q;

    // Input dropping early clears the count, so no pulse appears
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= 6'h00;
            out_q <= 1'b0;
        end
        else if (!db.level_in)
        begin
            cnt_q <= 6'h00;
            out_q <= 1'b0;
        end
        else if (cnt_q == db.count)
        begin
            out_q <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 6'h01;
        end
    end

    assign db.out = out_q;

endmodule // cwg_deadband

// file: rtl/cwg_modes.sv
// Purpose: Mode, steering and polarity logic of a complementary waveform generator
// Assumes: data_in and shutdown_n are asynchronous pins; AHB-Lite single word transfers
// Notes: Outputs are registered; pins see two sync stages plus one output stage
`timescale 1ns/1ns

// Function
// - Outputs derive from one input, with optional dead time between them.
// - Three-bit mode field selects six operating modes.
// - Half-bridge: A true, B inverted, dead band between; no steering.
// - Half-bridge: C and D mirror A and B with own polarity.
// - Push-pull: successive input pulses alternate between A and B.
// - Push-pull sequencer resets when disabled or shut down.
// - Sequencer advances on pulses; first pulse after reset goes to A.
// - Push-pull: C and D copy A and B with own polarity.
// - Forward full-bridge: A active, B and C inactive, D modulated.
// - Reverse full-bridge: C active, A and D inactive, B modulated.
// - Direction toggles by mode bit zero alone, while running.
// - Direction change takes effect at next rising input edge.
// - On direction change A and C swap; new modulation waits dead band.
// - Full-bridge dead band only on modulated output at direction change.
// - Steering routes input to any outputs, fixed levels elsewhere, no dead band.
// - Steer bit clear holds override level; set drives modulated input.
// - Polarity applies only to steered outputs.
// - Only steer bits are synchronised; override data acts at once.
// - Shutdown in steering overrides only steered outputs.
// - Synchronous steering updates at next rising input edge.
// - Asynchronous steering updates right after the write.
// - Dead band counts clock periods to a 6-bit value; zero means none.
// - Input reversing before count ends gives no pulse.
// - Polarity set means active high; shutdown levels ignore polarity.
// - Dead-band counts double-buffered with load request handshake.
module cwg_modes
    import cwg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic data_in,
    input wire logic shutdown_n,
    output logic out_a,
    output logic out_b,
    output logic out_c,
    output logic out_d
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic en_q;
    logic ld_q;
    logic [2:0] mode_q;
    logic [3:0] pol_q;
    logic [DB_W-1:0] dbr_q;
    logic [DB_W-1:0] dbf_q;
    logic [DB_W-1:0] dbr_act_q;
    logic [DB_W-1:0] dbf_act_q;
    logic [3:0] str_q;
    logic [3:0] str_sync_q;
    logic [3:0] sdat_q;
    logic [3:0] shdn_lvl_q;
    logic sw_shdn_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic rd_wait_q;
    logic [7:0] rd_addr_q;
    logic [31:0] hrdata_q;
    logic [1:0] din_sync_q;
    logic din_prev_q;
    logic [1:0] shdn_sync_q;
    logic ld_fell_q;
    logic pp_q;
    logic fb_dir_q;
    logic [DB_W-1:0] fb_wait_q;
    logic [3:0] out_q;
    logic din;
    logic din_rise;
    logic din_fall;
    logic shdn_act;
    logic db_load;
    logic ld_wr_set;
    logic is_fb;
    logic [3:0] str_act;
    logic [3:0] v;
    logic [3:0] pol_mask;
    logic [3:0] sd_mask;
    logic [3:0] out_d_nxt;

    cwg_db_if db_r ();
    cwg_db_if db_f ();

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rd_word(input logic [7:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (a)
            OFS_CTRL:
            begin
                w[CTRL_EN_BIT] = en_q;
                w[CTRL_LD_BIT] = ld_q;
                w[CTRL_MODE_LSB +: 3] = mode_q;
            end
            OFS_POL: w[3:0] = pol_q;
            OFS_DBR: w[DB_W-1:0] = dbr_q;
            OFS_DBF: w[DB_W-1:0] = dbf_q;
            OFS_STEER:
            begin
                w[STEER_STR_LSB +: 4] = str_q;
                w[STEER_SDAT_LSB +: 4] = sdat_q;
            end
            OFS_SHDN:
            begin
                w[SHDN_LVL_LSB +: 4] = shdn_lvl_q;
                w[SHDN_SW_BIT] = sw_shdn_q;
            end
            OFS_STATUS:
            begin
                w[STAT_OUT_LSB +: 4] = out_q;
                w[STAT_SHDN_BIT] = shdn_act;
                w[STAT_DIR_BIT] = fb_dir_q;
                w[STAT_PP_BIT] = pp_q;
                w[STAT_DBR_LSB +: DB_W] = dbr_act_q;
                w[STAT_DBF_LSB +: DB_W] = dbf_act_q;
            end
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    // Reads take one wait state so a write just before is visible
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rd_wait_q <= 1'b0;
            rd_addr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_q <= 1'b0;
            rd_wait_q <= 1'b0;
            if (hsel && htrans[1] && hready)
            begin
                wr_pend_q <= hwrite;
                rd_wait_q <= !hwrite;
                wr_addr_q <= haddr[7:0];
                rd_addr_q <= haddr[7:0];
            end
            if (rd_wait_q)
            begin
                hrdata_q <= rd_word(rd_addr_q);
            end
        end
    end

    assign hreadyout = !rd_wait_q;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign ld_wr_set = wr_pend_q && (wr_addr_q == OFS_CTRL) && hwdata[CTRL_LD_BIT];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Mode changes are taken at any time; keeping them to disabled periods is up to software
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            en_q <= 1'b0;
            mode_q <= RST_MODE;
            pol_q <= RST_POL;
            dbr_q <= RST_DB;
            dbf_q <= RST_DB;
            str_q <= RST_STR;
            sdat_q <= RST_SDAT;
            shdn_lvl_q <= RST_SHDN_LVL;
            sw_shdn_q <= 1'b0;
        end
        else if (wr_pend_q)
        begin
            unique case (wr_addr_q)
                OFS_CTRL:
                begin
                    en_q <= hwdata[CTRL_EN_BIT];
                    mode_q <= hwdata[CTRL_MODE_LSB +: 3];
                end
                OFS_POL: pol_q <= hwdata[3:0];
                OFS_DBR: dbr_q <= hwdata[DB_W-1:0];
                OFS_DBF: dbf_q <= hwdata[DB_W-1:0];
                OFS_STEER:
                begin
                    str_q <= hwdata[STEER_STR_LSB +: 4];
                    sdat_q <= hwdata[STEER_SDAT_LSB +: 4];
                end
                OFS_SHDN:
                begin
                    shdn_lvl_q <= hwdata[SHDN_LVL_LSB +: 4];
                    sw_shdn_q <= hwdata[SHDN_SW_BIT];
                end
                default: ;
            endcase
        end
    end

    // Load request: a new write setting it wins over the hardware clear
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ld_q <= 1'b0;
        end
        else if (ld_wr_set)
        begin
            ld_q <= 1'b1;
        end
        else if (db_load || (wr_pend_q && wr_addr_q == OFS_CTRL))
        begin
            ld_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers and edges
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            din_sync_q <= 2'b00;
            din_prev_q <= 1'b0;
            shdn_sync_q <= 2'b11;
        end
        else
        begin
            din_sync_q <= {din_sync_q[0], data_in};
            din_prev_q <= din_sync_q[1];
            shdn_sync_q <= {shdn_sync_q[0], shutdown_n};
        end
    end

    assign din = din_sync_q[1];
    assign din_rise = din && !din_prev_q;
    assign din_fall = !din && din_prev_q;
    assign shdn_act = sw_shdn_q || !shdn_sync_q[1];
    assign is_fb = (mode_q == MODE_FWD) || (mode_q == MODE_REV);

    // ------------------------------------------------------------
    // Dead-band count buffers
    // ------------------------------------------------------------
    assign db_load = en_q && ld_q && ld_fell_q && din_rise;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            dbr_act_q <= RST_DB;
            dbf_act_q <= RST_DB;
            ld_fell_q <= 1'b0;
        end
        else if (!en_q)
        begin
            dbr_act_q <= dbr_q;
            dbf_act_q <= dbf_q;
            ld_fell_q <= 1'b0;
        end
        else if (db_load)
        begin
            dbr_act_q <= dbr_q;
            dbf_act_q <= dbf_q;
            ld_fell_q <= 1'b0;
        end
        else if (ld_q && din_fall)
        begin
            ld_fell_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Half-bridge dead-band timers
    // ------------------------------------------------------------
    assign db_r.level_in = en_q && (mode_q == MODE_HALF) && din;
    assign db_r.count = dbr_act_q;
    assign db_f.level_in = en_q && (mode_q == MODE_HALF) && !din;
    assign db_f.count = dbf_act_q;

    cwg_deadband u_db_rise
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .db(db_r.timer)
    );

    cwg_deadband u_db_fall
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .db(db_f.timer)
    );

    // ------------------------------------------------------------
    // Push-pull sequencer
    // ------------------------------------------------------------
    // Toggle on the falling edge so each whole pulse stays on one output
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pp_q <= 1'b0;
        end
        else if (!en_q || shdn_act)
        begin
            pp_q <= 1'b0;
        end
        else if (mode_q == MODE_PUSH && din_fall)
        begin
            pp_q <= !pp_q;
        end
    end

    // ------------------------------------------------------------
    // Full-bridge direction
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            fb_dir_q <= 1'b0;
            fb_wait_q <= RST_DB;
        end
        else if (!en_q || !is_fb)
        begin
            fb_dir_q <= mode_q[0];
            fb_wait_q <= RST_DB;
        end
        else if (din_rise && (mode_q[0] != fb_dir_q))
        begin
            fb_dir_q <= mode_q[0];
            fb_wait_q <= mode_q[0] ? dbr_act_q : dbf_act_q;
        end
        else if (fb_wait_q != RST_DB)
        begin
            fb_wait_q <= fb_wait_q - 6'h01;
        end
    end

    // ------------------------------------------------------------
    // Steering selection
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            str_sync_q <= RST_STR;
        end
        else if (!en_q || mode_q != MODE_SSTEER || din_rise)
        begin
            str_sync_q <= str_q;
        end
    end

    // New selection on the edge itself, so no runt pulse
    assign str_act = (mode_q == MODE_SSTEER && !din_rise) ? str_sync_q : str_q;

    // ------------------------------------------------------------
    // Output selection; bit 0 is A, bit 3 is D
    // ------------------------------------------------------------
    always_comb
    begin
        v = 4'h0;
        pol_mask = 4'hF;
        sd_mask = 4'hF;
        unique case (mode_q)
            MODE_HALF:
            begin
                v = {db_f.out, db_r.out, db_f.out, db_r.out};
            end
            MODE_PUSH:
            begin
                v = {din && pp_q, din && !pp_q, din && pp_q, din && !pp_q};
            end
            MODE_FWD, MODE_REV:
            begin
                if (!fb_dir_q)
                begin
                    v = {din && (fb_wait_q == RST_DB), 1'b0, 1'b0, 1'b1};
                end
                else
                begin
                    v = {1'b0, 1'b1, din && (fb_wait_q == RST_DB), 1'b0};
                end
            end
            MODE_ASTEER, MODE_SSTEER:
            begin
                v = (str_act & {4{din}}) | (~str_act & sdat_q);
                pol_mask = str_act;
                sd_mask = str_act;
            end
            default:
            begin
                v = 4'h0;
            end
        endcase
        out_d_nxt = v ^ (pol_mask & ~pol_q);
        if (shdn_act)
        begin
            out_d_nxt = (sd_mask & shdn_lvl_q) | (~sd_mask & out_d_nxt);
        end
        if (!en_q)
        begin
            out_d_nxt = ~pol_q;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            out_q <= ~RST_POL;
        end
        else
        begin
            out_q <= out_d_nxt;
        end
    end

    assign out_a = out_q[0];
    assign out_b = out_q[1];
    assign out_c = out_q[2];
    assign out_d = out_q[3];

endmodule // cwg_modes

// file: tb/cwg_modes_sva.sv
// Purpose: Port-level checks of the waveform mode block
// Assumes: Register contents are mirrored from observed bus writes
// Notes: Mode checks wait until registers are quiet; all but steer_hold_a also wait until no shutdown was seen
`timescale 1ns/1ns
module cwg_modes_sva
    import cwg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic data_in,
    input wire logic shutdown_n,
    input wire logic out_a,
    input wire logic out_b,
    input wire logic out_c,
    input wire logic out_d
);
    logic wr_q;
    logic shut_q;
    logic [7:0] wadr_q;
    logic [7:0] ctrl_q;
    logic [3:0] pol_q;
    logic [11:0] steer_q;
    logic [2:0] quiet_q;
    logic [3:0] outs;
    logic [3:0] act;
    logic run;
    assign outs = {out_d, out_c, out_b, out_a};
    assign act = outs ^ ~pol_q;
    // Shutdown latches with no restart, so later mode checks other than steer_hold_a stay off
    assign run = ctrl_q[CTRL_EN_BIT] && quiet_q >= 3'h4 && !shut_q;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            wr_q <= 1'b0;
            wadr_q <= 8'h00;
        end
        else if (hready)
        begin
            wr_q <= hsel && htrans[1] && hwrite;
            wadr_q <= haddr[7:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ctrl_q <= 8'h00;
            pol_q <= RST_POL;
            steer_q <= 12'h000;
            quiet_q <= 3'h0;
            shut_q <= 1'b0;
        end
        else
        begin
            if (wr_q && hready && wadr_q == OFS_CTRL)
                ctrl_q <= hwdata[7:0];
            if (wr_q && hready && wadr_q == OFS_POL)
                pol_q <= hwdata[3:0];
            if (wr_q && hready && wadr_q == OFS_STEER)
                steer_q <= hwdata[11:0];
            if (wr_q && hready)
                quiet_q <= 3'h0;
            else if (quiet_q != 3'h7)
                quiet_q <= quiet_q + 3'h1;
            if (!shutdown_n)
                shut_q <= 1'b1;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence steer_run_s;
        run && ctrl_q[2:0] == MODE_ASTEER;
    endsequence
    sequence fb_run_s;
        run && ctrl_q[2:1] == 2'b01;
    endsequence

    disabled_idle_a: assert property (!ctrl_q[CTRL_EN_BIT] && quiet_q >= 3'h4 |-> outs == ~pol_q)
        else $error("outputs not idle while disabled");
    half_overlap_a: assert property (run && ctrl_q[2:0] == MODE_HALF |-> !(act[0] && act[1]))
        else $error("half-bridge outputs overlap");
    push_overlap_a: assert property (run && ctrl_q[2:0] == MODE_PUSH |-> !(act[0] && act[1]))
        else $error("push-pull outputs overlap");
    mirror_cd_a: assert property (run && ctrl_q[2] && !ctrl_q[1] |-> act[3:2] == act[1:0])
        else $error("outputs c and d do not mirror a and b");
    fb_static_a: assert property (fb_run_s |-> act[0] != act[2])
        else $error("static full-bridge outputs not opposite");
    fb_single_a: assert property (fb_run_s |-> (act[0] ? !act[1] : !act[3]))
        else $error("wrong full-bridge output modulated");
    steer_hold_a: assert property (ctrl_q[CTRL_EN_BIT] && ctrl_q[2:0] == MODE_ASTEER
        && quiet_q >= 3'h4 |-> ((outs ^ steer_q[11:8]) & ~steer_q[3:0]) == 4'h0)
        else $error("unsteered output left its override level");
    steer_path_a: assert property (steer_run_s
        |-> ((act ^ {4{$past(data_in, 3)}}) & steer_q[3:0]) == 4'h0)
        else $error("steered output does not follow input");
endmodule // cwg_modes_sva

bind cwg_modes cwg_modes_sva u_sva (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .data_in(data_in), .shutdown_n(shutdown_n),
    .out_a(out_a), .out_b(out_b), .out_c(out_c), .out_d(out_d));

// file: tb/gate_drv_model.sv
// Purpose: Gate driver stand-in counting switch turn-on events
// Assumes: A high level on a gate line turns its switch on
// Notes: Counters wrap; tests compare differences only
`timescale 1ns/1ns
module gate_drv_model
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] gate,
    output logic [3:0][7:0] rises
);
    logic [3:0] gate_q;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            gate_q <= 4'h0;
            rises <= '0;
        end
        else
        begin
            gate_q <= gate;
            for (int i = 0; i < 4; i++)
                if (gate[i] && !gate_q[i])
                    rises[i] <= rises[i] + 8'h01;
        end
    end
endmodule // gate_drv_model

// file: tb/cwg_modes_tb.sv
// Purpose: Self-checking bench of the waveform mode block
// Assumes: Single AHB-Lite master, gate driver model on the outputs
// Notes: Shutdown is exercised last because it does not restart
`timescale 1ns/1ns
`define CHK(nm, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
            n_fail++; \
        end \
    end
module cwg_modes_tb
    import cwg_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst, hsel, hwrite, hready, hreadyout, hresp, data_in, shutdown_n;
    logic out_a, out_b, out_c, out_d;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [3:0] outs;
    logic [3:0][7:0] rises, base;
    int n_fail = 0;
    int samples_checked = 0;
    int n;
    localparam logic [31:0] EN_W = 32'h00000080;
    assign hready = hreadyout;
    assign outs = {out_d, out_c, out_b, out_a};
    always #2 clk_sys = ~clk_sys;

    cwg_modes dut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .data_in(data_in), .shutdown_n(shutdown_n), .out_a(out_a), .out_b(out_b), .out_c(out_c), .out_d(out_d));
    gate_drv_model drv (.clk_sys(clk_sys), .rst(rst), .gate(outs), .rises(rises));

    task final_report;
        if (n_fail == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask

    task wait_rdy;
        int k;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (hreadyout !== 1'b1 && k < 20);
        if (hreadyout !== 1'b1)
        begin
            n_fail++;
            final_report();
        end
    endtask

    // Address phase held until hready, then data phase until hready
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task wait_out(input int i, input logic v);
        n = 0;
        do
        begin
            tick(1);
            n++;
        end
        while (outs[i] !== v && n < 100);
        if (outs[i] !== v)
        begin
            n_fail++;
            final_report();
        end
    endtask

    task pulse(input int h, input int l);
        data_in <= 1'b1;
        tick(h);
        data_in <= 1'b0;
        tick(l);
    endtask

    initial
    begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        data_in = 1'b0;
        shutdown_n = 1'b1;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        tick(1);
        bus(1'b0, OFS_POL, 32'h0);
        `CHK("pol reset", 32'h0000000F, rd)
        `CHK("idle reset", 4'h0, outs)
        wr(8'h40, 32'hFFFFFFFF);
        bus(1'b0, 8'h40, 32'h0);
        `CHK("unmapped", 32'h00000000, rd)
        `CHK("resp", 1'b0, hresp)
        wr(OFS_POL, 32'h5);
        tick(4);
        `CHK("idle pol", 4'hA, outs)
        wr(OFS_POL, 32'hF);
        wr(OFS_DBR, 32'h2);
        wr(OFS_DBF, 32'h3);
        bus(1'b0, OFS_DBR, 32'h0);
        `CHK("dbr", 32'h00000002, rd)
        wr(OFS_CTRL, EN_W | MODE_HALF);
        tick(8);
        data_in <= 1'b1;
        wait_out(0, 1'b1);
        `CHK("rise delay", 6, n)
        tick(10);
        `CHK("half high", 4'h5, outs)
        data_in <= 1'b0;
        wait_out(1, 1'b1);
        `CHK("fall delay", 7, n)
        tick(4);
        `CHK("half low", 4'hA, outs)
        base = rises;
        pulse(2, 12);
        `CHK("short pulse", base[0], rises[0])
        wr(OFS_CTRL, 32'h0);
        wr(OFS_CTRL, EN_W | MODE_PUSH);
        tick(4);
        base = rises;
        pulse(8, 8);
        `CHK("push first", base[0] + 8'h01, rises[0])
        pulse(8, 8);
        pulse(8, 8);
        `CHK("push a", base[0] + 8'h02, rises[0])
        `CHK("push b", base[1] + 8'h01, rises[1])
        wr(OFS_CTRL, 32'h0);
        wr(OFS_CTRL, EN_W | MODE_PUSH);
        tick(4);
        pulse(8, 8);
        `CHK("push restart", base[0] + 8'h03, rises[0])
        `CHK("push c", base[2] + 8'h03, rises[2])
        `CHK("push d", base[3] + 8'h01, rises[3])
        wr(OFS_CTRL, 32'h0);
        wr(OFS_CTRL, EN_W | MODE_FWD);
        tick(6);
        `CHK("fwd idle", 4'h1, outs)
        data_in <= 1'b1;
        tick(6);
        `CHK("fwd mod", 4'h9, outs)
        data_in <= 1'b0;
        tick(6);
        wr(OFS_CTRL, EN_W | MODE_REV);
        tick(6);
        `CHK("dir pending", 4'h1, outs)
        data_in <= 1'b1;
        tick(4);
        `CHK("dir swap", 4'h4, outs)
        wait_out(1, 1'b1);
        `CHK("rev mod", 4'h6, outs)
        data_in <= 1'b0;
        tick(6);
        `CHK("rev idle", 4'h4, outs)
        wr(OFS_CTRL, 32'h0);
        wr(OFS_STEER, 32'h001);
        wr(OFS_CTRL, EN_W | MODE_SSTEER);
        tick(4);
        data_in <= 1'b1;
        tick(5);
        `CHK("sync a", 4'h1, outs)
        wr(OFS_STEER, 32'h002);
        tick(4);
        `CHK("sync hold", 4'h1, outs)
        data_in <= 1'b0;
        tick(5);
        data_in <= 1'b1;
        tick(5);
        `CHK("sync b", 4'h2, outs)
        data_in <= 1'b0;
        wr(OFS_CTRL, 32'h0);
        wr(OFS_POL, 32'hB);
        wr(OFS_STEER, 32'h205);
        wr(OFS_CTRL, EN_W | MODE_ASTEER);
        tick(5);
        `CHK("async low", 4'h6, outs)
        data_in <= 1'b1;
        tick(5);
        `CHK("async high", 4'h3, outs)
        wr(OFS_STEER, 32'h005);
        tick(2);
        `CHK("async data", 4'h1, outs)
        wr(OFS_STEER, 32'h004);
        tick(2);
        `CHK("async steer", 4'h0, outs)
        wr(OFS_STEER, 32'h205);
        tick(2);
        shutdown_n <= 1'b0;
        tick(6);
        `CHK("shutdown", 4'h2, outs)
        final_report();
    end
endmodule // cwg_modes_tb
